// file: verilog/monitor_defs.svh
`ifndef MONITOR_DEFS_SVH
`define MONITOR_DEFS_SVH

// register pointers
`define ADDR_CFG 8'h00
`define ADDR_FLAGS 8'h01
`define ADDR_GATING 8'h02
`define ADDR_SHUNT 8'h03
`define ADDR_OVLIM 8'h12

// reset values
`define CFG_RESET 16'h399f
`define FLAGS_RESET 16'h0000
`define GATING_RESET 16'h0000
`define OVLIM_RESET 16'h0000
`define ZERO16 16'h0000

// configuration fields
`define CFG_RST_BIT 15
`define CFG_GAIN_HI 12
`define CFG_GAIN_LO 11
`define CFG_MODE_HI 2
`define CFG_MODE_LO 0
`define MODE_POWER_DOWN 3'h0
`define MODE_ADC_OFF 3'h4

// over-limit control fields
`define OVLIM_POL_BIT 0
`define OVLIM_LATCH_BIT 1

// status flag positions
`define FLAG_HIT_HI 15
`define FLAG_HIT_LO 6
`define FLAG_WARN_HI 15
`define FLAG_WARN_LO 11
`define FLAG_LIMIT_HI 10
`define FLAG_LIMIT_LO 8
`define FLAG_SEVERE_HI 7
`define FLAG_SEVERE_LO 6
`define FLAG_GATED_LO 5
`define FLAG_CONV 5
`define FLAG_ALERT 4
`define FLAG_MATH 3
`define FLAG_UNUSED_HI 2

// gating fields
`define GATE_ALERT_EN 3
`define GATE_SEVERE_EN 2
`define GATE_LIMIT_EN 1
`define GATE_WARN_EN 0

// shunt span per gain, in counts of 10 uV
`define SHUNT_POS_DIV8 16'sh7d00
`define SHUNT_NEG_DIV8 16'sh8300
`define SHUNT_POS_DIV4 16'sh3e80
`define SHUNT_NEG_DIV4 16'shc180
`define SHUNT_POS_DIV2 16'sh1f40
`define SHUNT_NEG_DIV2 16'she0c0
`define SHUNT_POS_X1 16'sh0fa0
`define SHUNT_NEG_X1 16'shf060

`endif

// file: verilog/monitor_pkg.sv
package monitor_pkg;
  typedef enum logic [1:0]
  {
    GAIN_X1 = 2'b00,
    GAIN_DIV2 = 2'b01,
    GAIN_DIV4 = 2'b10,
    GAIN_DIV8 = 2'b11
  } shunt_gain_select_t;
endpackage

// file: verilog/shunt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface shunt_if;
  import monitor_pkg::*;
  logic signed [15:0] raw;
  logic raw_valid;
  shunt_gain_select_t gain;
  logic [15:0] result;
  modport source (output raw, output raw_valid, output gain, input result);
  modport clamp (input raw, input raw_valid, input gain, output result);
endinterface
`default_nettype wire

// file: verilog/shunt_clamp.sv
`timescale 1ns/1ps
`default_nettype none
`include "monitor_defs.svh"
module shunt_clamp (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic ce,
  shunt_if.clamp sh
);
  import monitor_pkg::*;

  typedef struct packed {
    logic [15:0] result;
  } clamp_state_t;

  clamp_state_t s_reg;
  clamp_state_t s_next;
  logic signed [15:0] pos_lim;
  logic signed [15:0] neg_lim;

  always_comb
  begin
    unique case (sh.gain)
      GAIN_DIV8:
      begin
        pos_lim = `SHUNT_POS_DIV8;
        neg_lim = `SHUNT_NEG_DIV8;
      end
      GAIN_DIV4:
      begin
        pos_lim = `SHUNT_POS_DIV4;
        neg_lim = `SHUNT_NEG_DIV4;
      end
      GAIN_DIV2:
      begin
        pos_lim = `SHUNT_POS_DIV2;
        neg_lim = `SHUNT_NEG_DIV2;
      end
      GAIN_X1:
      begin
        pos_lim = `SHUNT_POS_X1;
        neg_lim = `SHUNT_NEG_X1;
      end
    endcase
  end

  // saturating at the span keeps every sign position equal to the sign
  always_comb
  begin
    s_next = s_reg;
    if (ce && sh.raw_valid)
    begin
      if (sh.raw > pos_lim)
        s_next.result = pos_lim;
      else if (sh.raw < neg_lim)
        s_next.result = neg_lim;
      else
        s_next.result = sh.raw;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign sh.result = s_reg.result;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_shunt_span_div8: assert property ((sh.gain == GAIN_DIV8) |->
    ($signed(s_reg.result) <= 16'sh7d00 && $signed(s_reg.result) >= 16'sh8300) || $changed(sh.gain))
    else $error("shunt result outside div8 span");
  a_shunt_clamp_x1: assert property ((ce && sh.raw_valid && sh.gain == GAIN_X1 && sh.raw > 16'sh0fa0)
    |=> s_reg.result == 16'h0fa0)
    else $error("shunt result not clamped at gain one");
  a_shunt_clamp_neg: assert property ((ce && sh.raw_valid && sh.gain == GAIN_DIV2 && sh.raw < 16'she0c0)
    |=> s_reg.result == 16'he0c0)
    else $error("shunt negative clamp wrong at div2");
  c_shunt_clamped: cover property (ce && sh.raw_valid && sh.raw > pos_lim);
endmodule
`default_nettype wire

// file: verilog/monitor_status_alert_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "monitor_defs.svh"
// Function
// - limit flags set on violation; hold while their latch enable is on
// - status read clears flags; a still-violated limit sets again at once
// - bit 15 bus high warning, bit 14 bus low warning
// - bit 13 power warning
// - bit 12 shunt positive warning, bit 11 shunt negative warning
// - bit 10 bus high over-limit, bit 9 bus low over-limit
// - bit 8 power over-limit
// - bit 7 shunt positive severe, bit 6 shunt negative severe
// - bit 5 sets only once a whole conversion cycle finished
// - bit 5 clears on config write (not off modes), status read, convert pin
// - bit 4 clears only on status read or alert disable
// - bit 3 marks arithmetic overflow and drives no watchdog pin
// - gating bits 5..15 gate same status bit from alert, not from setting
// - a zero gating bit blocks its flag's alert, not the flag; all gating bits reset to zero
// - gating bit 3 enables the alert output, reset zero
// - gating bits 2,1,0 enable severe, limit, warn pins; reset zero
// - shunt result is 16-bit two's complement with equal sign bits
// - divide-by-8: sign bit 15 only, span 32000 counts
// - divide-by-4: sign bits 15..14, span 16000 counts
// - divide-by-2: sign bits 15..13, span 8000 counts
// - gain one: sign bits 15..12, span 4000 counts
// - gain field is two config bits, default divide-by-8
// - over-limit pin latch and polarity sit in register 12h
module monitor_status_alert_regs #(
  parameter int DATA_W = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [15:6] limit_hit,
  input wire logic warn_latch_en,
  input wire logic severe_latch_en,
  input wire logic conv_done,
  input wire logic math_overflow,
  input wire logic signed [DATA_W-1:0] shunt_raw,
  input wire logic shunt_raw_valid,
  input wire logic convert_pin,
  output logic [DATA_W-1:0] cfg_out,
  output logic smbus_alert_n,
  output logic warn_pin,
  output logic limit_pin,
  output logic severe_pin
);
  import monitor_pkg::*;

  generate
    if (DATA_W != 16)
    begin : g_width_check
      $error("registers are 16 bits wide");
    end
  endgenerate

  typedef struct packed {
    logic [15:0] flags;
    logic [15:0] gating;
    logic [15:0] cfg_word;
    logic [15:0] ovlim_ctl;
    logic [15:0] rdata;
    logic [2:0] conv_sync;
    logic alert_n;
    logic warn;
    logic limit;
    logic severe;
  } mon_state_t;

  localparam mon_state_t STATE_RESET = '{
    flags: `FLAGS_RESET,
    gating: `GATING_RESET,
    cfg_word: `CFG_RESET,
    ovlim_ctl: `OVLIM_RESET,
    rdata: `ZERO16,
    conv_sync: 3'h0,
    alert_n: 1'b1,
    warn: 1'b0,
    limit: 1'b0,
    severe: 1'b0
  };

  mon_state_t s_reg;
  mon_state_t s_next;
  shunt_if sh ();

  logic rd_status;
  logic cfg_write;
  logic cfg_clears_conv;
  logic conv_edge;
  logic [15:6] latch_hold;
  logic alert_cond;
  logic [2:0] wr_mode;

  assign sh.raw = shunt_raw;
  assign sh.raw_valid = shunt_raw_valid;
  assign sh.gain = shunt_gain_select_t'(s_reg.cfg_word[`CFG_GAIN_HI:`CFG_GAIN_LO]);

  shunt_clamp u_clamp (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .ce(ce),
    .sh(sh)
  );

  always_comb
  begin
    rd_status = reg_rd && (reg_addr == `ADDR_FLAGS);
    cfg_write = reg_wr && (reg_addr == `ADDR_CFG);
    wr_mode = reg_wdata[`CFG_MODE_HI:`CFG_MODE_LO];
    // off modes leave the last conversion marked ready
    cfg_clears_conv = cfg_write && (wr_mode != `MODE_POWER_DOWN) && (wr_mode != `MODE_ADC_OFF);
    // edge taken between second and third stage, never from the first
    conv_edge = s_reg.conv_sync[1] && !s_reg.conv_sync[2];
    latch_hold[`FLAG_WARN_HI:`FLAG_WARN_LO] = {5{warn_latch_en}};
    latch_hold[`FLAG_LIMIT_HI:`FLAG_LIMIT_LO] = {3{s_reg.ovlim_ctl[`OVLIM_LATCH_BIT]}};
    latch_hold[`FLAG_SEVERE_HI:`FLAG_SEVERE_LO] = {2{severe_latch_en}};
  end

  always_comb
  begin
    alert_cond = 1'b0;
    s_next = s_reg;
    if (ce)
    begin
      s_next.conv_sync = {s_reg.conv_sync[1:0], convert_pin};

      // comparator flags: transparent unless latched; set beats read clear
      s_next.flags[`FLAG_HIT_HI:`FLAG_HIT_LO] = limit_hit
        | (latch_hold & s_reg.flags[`FLAG_HIT_HI:`FLAG_HIT_LO] & {10{!rd_status}});
      s_next.flags[`FLAG_CONV] = conv_done
        | (s_reg.flags[`FLAG_CONV] & !(rd_status || cfg_clears_conv || conv_edge));
      s_next.flags[`FLAG_MATH] = math_overflow | (s_reg.flags[`FLAG_MATH] & !rd_status);
      s_next.flags[`FLAG_UNUSED_HI:0] = 3'h0;

      if (reg_wr && reg_addr == `ADDR_GATING)
        s_next.gating = reg_wdata;
      if (reg_wr && reg_addr == `ADDR_OVLIM)
        s_next.ovlim_ctl = reg_wdata;
      if (cfg_write)
        s_next.cfg_word = reg_wdata;
      // self-clearing reset bit returns flags, gating, config and over-limit control to power-on values
      if (cfg_write && reg_wdata[`CFG_RST_BIT])
      begin
        // an event in the reset cycle still sets its flag, as after power-up
        s_next.flags = `FLAGS_RESET | {limit_hit, conv_done, 1'b0, math_overflow, 3'h0};
        s_next.gating = `GATING_RESET;
        s_next.cfg_word = `CFG_RESET;
        s_next.ovlim_ctl = `OVLIM_RESET;
      end
      s_next.gating[`FLAG_ALERT] = 1'b0;

      // gating blocks the alert only, never the flag itself
      alert_cond = s_next.gating[`GATE_ALERT_EN]
        && |(s_next.flags[`FLAG_HIT_HI:`FLAG_GATED_LO] & s_next.gating[`FLAG_HIT_HI:`FLAG_GATED_LO]);
      s_next.flags[`FLAG_ALERT] = alert_cond
        | (s_reg.flags[`FLAG_ALERT] & !rd_status & s_next.gating[`GATE_ALERT_EN]);
      s_next.alert_n = !alert_cond;

      // pins see comparator groups only; math overrun is left out
      s_next.warn = s_next.gating[`GATE_WARN_EN]
        && |s_next.flags[`FLAG_WARN_HI:`FLAG_WARN_LO];
      s_next.limit = (s_next.gating[`GATE_LIMIT_EN]
        && |s_next.flags[`FLAG_LIMIT_HI:`FLAG_LIMIT_LO]) ^ s_next.ovlim_ctl[`OVLIM_POL_BIT];
      s_next.severe = s_next.gating[`GATE_SEVERE_EN]
        && |s_next.flags[`FLAG_SEVERE_HI:`FLAG_SEVERE_LO];

      if (reg_rd)
      begin
        unique case (reg_addr)
          `ADDR_CFG: s_next.rdata = s_reg.cfg_word;
          `ADDR_FLAGS: s_next.rdata = s_reg.flags;
          `ADDR_GATING: s_next.rdata = s_reg.gating;
          `ADDR_SHUNT: s_next.rdata = sh.result;
          `ADDR_OVLIM: s_next.rdata = s_reg.ovlim_ctl;
          default: s_next.rdata = `ZERO16;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      s_reg <= STATE_RESET;
    else
      s_reg <= s_next;
  end

  always_comb
  begin
    reg_rdata = s_reg.rdata;
    cfg_out = s_reg.cfg_word;
    smbus_alert_n = s_reg.alert_n;
    warn_pin = s_reg.warn;
    limit_pin = s_reg.limit;
    severe_pin = s_reg.severe;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_bus_high_warn: assert property (ce && limit_hit[15] |=> s_reg.flags[15])
    else $error("bus high warning flag not set");
  a_power_warn_set: assert property (ce && limit_hit[13] |=> s_reg.flags[13])
    else $error("power warning flag not set");
  a_shunt_neg_warn: assert property (ce && limit_hit[11] |=> s_reg.flags[11])
    else $error("shunt negative warning flag not set");
  a_bus_low_limit: assert property (ce && limit_hit[9] |=> s_reg.flags[9])
    else $error("bus low limit flag not set");
  a_power_limit_set: assert property (ce && limit_hit[8] |=> s_reg.flags[8])
    else $error("power limit flag not set");
  a_severe_pos_set: assert property (ce && limit_hit[7] |=> s_reg.flags[7])
    else $error("shunt positive severe flag not set");
  a_latch_holds_flag: assert property (ce && warn_latch_en && s_reg.flags[12] && !rd_status
    && !(cfg_write && reg_wdata[`CFG_RST_BIT]) |=> s_reg.flags[12])
    else $error("latched warning flag dropped");
  a_read_clears_flag: assert property (ce && rd_status && !limit_hit[10] |=> !s_reg.flags[10])
    else $error("status read did not clear flag");
  a_conv_done_set: assert property (ce && conv_done |=> s_reg.flags[5])
    else $error("conversion done flag not set");
  a_conv_pin_clear: assert property (ce && conv_edge && !conv_done |=> !s_reg.flags[5])
    else $error("convert pin did not clear conversion flag");
  a_alert_disable_clr: assert property (ce && reg_wr && reg_addr == `ADDR_GATING && !reg_wdata[3]
    && !reg_wdata[15] |=> !s_reg.flags[4])
    else $error("alert flag survived alert disable");
  a_math_no_pin: assert property (ce && math_overflow && limit_hit == 10'h000 && !warn_latch_en
    && !severe_latch_en |=> !warn_pin && !severe_pin)
    else $error("overflow drove a watchdog pin");
  a_alert_follows_gate: assert property (s_reg.gating[3]
    && |(s_reg.flags[15:5] & s_reg.gating[15:5]) |-> !smbus_alert_n)
    else $error("alert missing for gated flag");
  a_masked_no_alert: assert property ((s_reg.gating[15:5] == 11'h000) |-> smbus_alert_n)
    else $error("alert raised with all flags masked");
  a_warn_pin_gate: assert property (!s_reg.gating[0] |-> !warn_pin)
    else $error("warn pin active while disabled");
  a_gain_default: assert property ($rose(reset_n) |-> sh.gain == GAIN_DIV8)
    else $error("gain not divide-by-8 after reset");

  c_alert_raised: cover property (ce && !s_reg.alert_n ##1 rd_status);
  c_latch_reset: cover property (ce && rd_status && limit_hit[15]);
  c_conv_cycle: cover property (ce && conv_done ##[1:20] conv_edge);
endmodule
`default_nettype wire

// file: verification/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
  end
  // idle lines carry the inverse of the last value, so a stale word never passes as live
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import monitor_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] cfg_out;
  logic [15:6] limit_hit = '0;
  logic warn_latch_en = 1'b0;
  logic severe_latch_en = 1'b0;
  logic conv_done = 1'b0;
  logic math_overflow = 1'b0;
  logic signed [15:0] shunt_raw = 16'sh0000;
  logic shunt_raw_valid = 1'b0;
  logic convert_pin = 1'b0;
  logic ce = 1'b1;
  logic smbus_alert_n;
  logic warn_pin;
  logic limit_pin;
  logic severe_pin;
  logic [15:0] span [4] = '{16'h0fa0, 16'h1f40, 16'h3e80, 16'h7d00};
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #2 core_clk = ~core_clk;

  monitor_status_alert_regs dut (.core_clk(core_clk), .reset_n(reset_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .limit_hit(limit_hit),
    .warn_latch_en(warn_latch_en), .severe_latch_en(severe_latch_en), .conv_done(conv_done),
    .math_overflow(math_overflow), .shunt_raw(shunt_raw), .shunt_raw_valid(shunt_raw_valid),
    .convert_pin(convert_pin), .cfg_out(cfg_out), .smbus_alert_n(smbus_alert_n), .warn_pin(warn_pin),
    .limit_pin(limit_pin), .severe_pin(severe_pin));

  host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
    logic [15:0] d;
    host.rd(a, d);
    chk(what, exp, d);
  endtask

  // event pulse on a comparator line, one cycle unless hold leaves it high, then let flags settle
  task automatic pulse_hit(input int n, input logic hold);
    @(negedge core_clk);
    limit_hit[n] = 1'b1;
    @(negedge core_clk);
    limit_hit[n] = hold;
    @(negedge core_clk);
  endtask

  // one-cycle pulse: 0 conv_done, 1 convert_pin, 2 math_overflow
  task automatic pulse(input int which);
    @(negedge core_clk);
    conv_done = (which == 0);
    convert_pin = (which == 1);
    math_overflow = (which == 2);
    @(negedge core_clk);
    conv_done = 1'b0;
    convert_pin = 1'b0;
    math_overflow = 1'b0;
    @(negedge core_clk);
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      stop_test();
    end
  end

  initial
  begin
    repeat (12) @(negedge core_clk);
    chk("cfg_out in reset", 16'h399f, cfg_out);
    reset_n = 1'b1;
    chk("alert after reset", 16'h0001, {15'h0, smbus_alert_n});
    rd_chk(8'h02, 16'h0000, "gating reset");
    rd_chk(8'h03, 16'h0000, "shunt reset");
    rd_chk(8'h01, 16'h0000, "flags after setup");
    host.wr(8'h7f, 16'hffff);
    rd_chk(8'h7f, 16'h0000, "unmapped");
    host.wr(8'h02, 16'hffff);
    rd_chk(8'h02, 16'hffef, "gating rw");
    host.wr(8'h02, 16'h0000);
    $display("test reset/regs done");

    warn_latch_en = 1'b1;
    severe_latch_en = 1'b1;
    host.wr(8'h12, 16'h0002);
    for (int n = 6; n < 16; n++)
    begin
      pulse_hit(n, 1'b0);
      chk("alert masked", 16'h0001, {15'h0, smbus_alert_n});
      rd_chk(8'h01, 16'h0001 << n, "latched flag");
    end
    rd_chk(8'h01, 16'h0000, "flags cleared");
    $display("test flag bits done");

    host.wr(8'h02, 16'h8009);
    pulse_hit(15, 1'b1);
    chk("alert on", 16'h0000, {15'h0, smbus_alert_n});
    rd_chk(8'h01, 16'h8010, "flags first read");
    rd_chk(8'h01, 16'h8010, "flags still hit");
    limit_hit[15] = 1'b0;
    rd_chk(8'h01, 16'h8010, "flags re-set");
    rd_chk(8'h01, 16'h0000, "flags clear");
    chk("alert off", 16'h0001, {15'h0, smbus_alert_n});
    host.wr(8'h02, 16'h0008);
    pulse_hit(14, 1'b0);
    chk("ungated alert", 16'h0001, {15'h0, smbus_alert_n});
    rd_chk(8'h01, 16'h4000, "ungated flag sets");
    host.wr(8'h02, 16'h8008);
    pulse_hit(15, 1'b0);
    host.wr(8'h02, 16'h8000);
    chk("alert disabled", 16'h0001, {15'h0, smbus_alert_n});
    rd_chk(8'h01, 16'h8000, "bit4 off by disable");
    $display("test alert done");

    pulse(0);
    host.wr(8'h00, 16'h399f);
    rd_chk(8'h01, 16'h0000, "ready cleared by cfg");
    pulse(0);
    host.wr(8'h00, 16'h3998);
    rd_chk(8'h01, 16'h0020, "ready kept in off mode");
    pulse(0);
    host.wr(8'h00, 16'h399c);
    rd_chk(8'h01, 16'h0020, "ready kept in adc off");
    host.wr(8'h00, 16'h399f);
    pulse(0);
    pulse(1);
    convert_pin = 1'b0;
    repeat (3) @(negedge core_clk);
    rd_chk(8'h01, 16'h0000, "ready cleared by pin");
    $display("test ready done");

    warn_latch_en = 1'b0;
    severe_latch_en = 1'b0;
    host.wr(8'h12, 16'h0000);
    host.wr(8'h02, 16'h0007);
    pulse(2);
    chk("overflow pins", 16'h0000, {13'h0, warn_pin, limit_pin, severe_pin});
    rd_chk(8'h01, 16'h0008, "overflow flag");
    pulse_hit(15, 1'b1);
    chk("warn pin", 16'h0001, {15'h0, warn_pin});
    limit_hit[15] = 1'b0;
    pulse_hit(8, 1'b1);
    chk("limit pin", 16'h0001, {15'h0, limit_pin});
    host.wr(8'h12, 16'h0001);
    @(negedge core_clk);
    chk("limit pin inverted", 16'h0000, {15'h0, limit_pin});
    limit_hit[8] = 1'b0;
    pulse_hit(7, 1'b1);
    chk("severe pin", 16'h0001, {15'h0, severe_pin});
    limit_hit[7] = 1'b0;
    rd_chk(8'h01, 16'h0000, "flags after pins");
    $display("test pins done");

    for (int g = 0; g < 4; g++)
    begin
      host.wr(8'h00, {3'b001, g[1:0], 11'h19f});
      for (int k = 0; k < 4; k++)
      begin
        @(negedge core_clk);
        shunt_raw = (k == 0) ? span[g] + 16'h1 : (k == 1) ? -(span[g] + 16'h1) : (k == 2) ? 16'sd3999 : -16'sd3999;
        shunt_raw_valid = 1'b1;
        @(negedge core_clk);
        shunt_raw_valid = 1'b0;
        rd_chk(8'h03, (k == 0) ? span[g] : (k == 1) ? -span[g] : (k == 2) ? 16'h0f9f : 16'hf061,
          "shunt result");
      end
    end
    host.wr(8'h03, 16'h1234);
    rd_chk(8'h03, 16'hf061, "shunt read only");
    host.wr(8'h00, 16'h8000);
    chk("soft reset cfg", 16'h399f, cfg_out);
    rd_chk(8'h02, 16'h0000, "soft reset gating");
    ce = 1'b0;
    host.wr(8'h02, 16'h0007);
    ce = 1'b1;
    rd_chk(8'h02, 16'h0000, "write frozen by ce");
    $display("test shunt done");
    stop_test();
  end
endmodule
`default_nettype wire
